/* File: dpfs_top.sv */
// module: dual-port fault status and alert logic with AXI4-Lite registers
// Operation
// - only the port in control clears the shared status
// - a clear from the owner leaves the other port's alert asserted while that port's pending bits or a persisting fault hold it
// - unit faults never touch the bus ownership status
// - normal or invalid command on non-owner port is rejected, recorded 0x1C/0xC1, alerts that port
// - invalid owner command sets comm error 0x80, read-back 0x0002, alerts issuer
// - takeover asserts both alerts, status 0x74 or 0x47
// - fault under port 0 control alerts and latches, status stays 0x01
// - idle status reads 0x01 for port 0 owner, 0x10 for port 1
// - a port's own clear drops alert kept only by its pending bits
// - fault bits latch until clear and reassert if the fault persists
// - operational state bits follow the live condition, never latched
// - output shutdown bit latches until an accepted clear
// - voltage, current, input, unknown, comm and int/ext faults all latch
// - isolation switch test result latches until cleared
// - response settings change only by controller write, never by clear
// - overcurrent response accepts only 0xc0 or 0xf8
// - overtemperature response accepts only 0x80 or 0xc0
// - output good only in regulation, drops before an imminent shutdown
// - alerts are active low and idle high
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module dpfs_top
#(
    parameter int ADDR_W = dpfs_pkg::ADDR_W,
    parameter int FAULT_W = dpfs_pkg::FAULT_W
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic port0_cmd_valid,
    input wire dpfs_pkg::dpfs_cmd_e port0_cmd_code,
    input wire logic port1_cmd_valid,
    input wire dpfs_pkg::dpfs_cmd_e port1_cmd_code,
    input wire logic [FAULT_W-1:0] fault_cond,
    input wire logic main_output_on,
    input wire logic output_in_regulation,
    input wire logic shutdown_imminent,
    output logic [1:0] alert_n,
    output logic output_good_flag,
    output logic owner_port
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic owner;
        logic [FAULT_W-1:0] faults;
        logic [7:0] cml;
        logic [15:0] readback;
        logic [7:0] oc_resp;
        logic [7:0] ot_resp;
        logic [2:0] live;
        logic [1:0] alert_n;
        logic good;
    } dpfs_state_s;

    dpfs_state_s st;
    dpfs_state_s next_st;

    dpfs_nib_if nib0 ();
    dpfs_nib_if nib1 ();

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic dpfs_is_cmd(input logic valid, input dpfs_pkg::dpfs_cmd_e code,
                                         input dpfs_pkg::dpfs_cmd_e want);
        dpfs_is_cmd = valid && (code == want);
    endfunction

    // commands that need control: everything but clear and takeover
    function automatic logic dpfs_needs_ctrl(input logic valid, input dpfs_pkg::dpfs_cmd_e code);
        dpfs_needs_ctrl = valid && (code == dpfs_pkg::DPFS_CMD_NORMAL
                                    || code == dpfs_pkg::DPFS_CMD_INVALID);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    logic clr0;
    logic clr1;
    logic take0;
    logic take1;
    logic bad_owner;
    logic owner_clr;

    always_comb
    begin
        clr0 = dpfs_is_cmd(port0_cmd_valid, port0_cmd_code, dpfs_pkg::DPFS_CMD_CLEAR);
        clr1 = dpfs_is_cmd(port1_cmd_valid, port1_cmd_code, dpfs_pkg::DPFS_CMD_CLEAR);
        // a simultaneous takeover goes to the port not in control, so one owner always results
        take0 = st.owner && dpfs_is_cmd(port0_cmd_valid, port0_cmd_code,
                                        dpfs_pkg::DPFS_CMD_TAKEOVER);
        take1 = !st.owner && !take0 && dpfs_is_cmd(port1_cmd_valid, port1_cmd_code,
                                                   dpfs_pkg::DPFS_CMD_TAKEOVER);
        bad_owner = st.owner ?
            dpfs_is_cmd(port1_cmd_valid, port1_cmd_code, dpfs_pkg::DPFS_CMD_INVALID) :
            dpfs_is_cmd(port0_cmd_valid, port0_cmd_code, dpfs_pkg::DPFS_CMD_INVALID);
        owner_clr = st.owner ? clr1 : clr0;
    end

    assign nib0.clr = clr0;
    assign nib1.clr = clr1;
    assign nib0.take = take0;
    assign nib1.take = take1;
    assign nib0.lose = take1;
    assign nib1.lose = take0;
    assign nib0.reject = st.owner && dpfs_needs_ctrl(port0_cmd_valid, port0_cmd_code);
    assign nib1.reject = !st.owner && dpfs_needs_ctrl(port1_cmd_valid, port1_cmd_code);
    assign nib0.owner = !st.owner;
    assign nib1.owner = st.owner;

    dpfs_nibble u_nib0
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .nif(nib0)
    );

    dpfs_nibble u_nib1
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .nif(nib1)
    );

    ////////////////////////////////////////////////////////////////////////////
    // status, alerts and register bus

    always_comb
    begin
        logic any_fault;
        logic cml_pend;
        logic [1:0] want_alert;
        logic [ADDR_W-1:0] ra;
        logic [7:0] wbyte;
        next_st = st;
        any_fault = 1'b0;
        cml_pend = 1'b0;
        want_alert = 2'b00;
        ra = s_axi_araddr;
        wbyte = st.wdata[7:0];

        // ownership changes only on takeover
        if (take0)
            next_st.owner = 1'b0;
        else if (take1)
            next_st.owner = 1'b1;

        // sticky faults: a clear from the owner restarts from the live condition
        // and the live condition is ORed in so a persisting fault reasserts
        next_st.faults = (owner_clr ? '0 : st.faults) | fault_cond;

        // communication error latches; set wins over a clear
        if (owner_clr)
        begin
            next_st.cml = dpfs_pkg::CML_NONE;
            next_st.readback = dpfs_pkg::RB_NONE;
        end
        if (bad_owner)
        begin
            next_st.cml = dpfs_pkg::CML_INVALID_CMD;
            next_st.readback = dpfs_pkg::RB_INVALID_CMD;
        end

        // operational state is a plain sample, untouched by clear
        next_st.live = {shutdown_imminent, output_in_regulation, main_output_on};

        // good only while regulating and no shutdown is coming
        next_st.good = output_in_regulation && !shutdown_imminent;

        // unit faults reach both alerts through shared status only, never the
        // ownership nibbles, so each nibble keeps its own port's alert up
        any_fault = |(next_st.faults & dpfs_pkg::FAULT_ALERT_MASK);
        cml_pend = next_st.cml != dpfs_pkg::CML_NONE;
        want_alert[0] = any_fault || (|nib0.nib[3:1]) || (cml_pend && !next_st.owner);
        want_alert[1] = any_fault || (|nib1.nib[3:1]) || (cml_pend && next_st.owner);
        // pending nibble bits land one cycle later, so fold in this cycle's events
        if (take0 || take1)
            want_alert = 2'b11;
        if (nib0.reject)
            want_alert[0] = 1'b1;
        if (nib1.reject)
            want_alert[1] = 1'b1;
        if (clr0 && !(take0 || take1 || nib0.reject))
            want_alert[0] = any_fault || (cml_pend && !next_st.owner);
        if (clr1 && !(take0 || take1 || nib1.reject))
            want_alert[1] = any_fault || (cml_pend && next_st.owner);
        next_st.alert_n = ~want_alert;

        // write channel: address and data taken in either order
        if (s_axi_awvalid && st.awready)
        begin
            next_st.aw_got = 1'b1;
            next_st.awready = 1'b0;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready)
        begin
            next_st.w_got = 1'b1;
            next_st.wready = 1'b0;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (st.aw_got && st.w_got && !st.bvalid)
        begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = dpfs_pkg::RESP_OKAY;
            unique case (st.awaddr)
                dpfs_pkg::ADDR_OC_RESP:
                begin
                    // unsupported codes refused, old setting kept
                    if (st.wstrb[0] && (wbyte == dpfs_pkg::OC_LATCH
                                        || wbyte == dpfs_pkg::OC_HICCUP))
                        next_st.oc_resp = wbyte;
                    else if (st.wstrb[0])
                        next_st.bresp = dpfs_pkg::RESP_SLVERR;
                end
                dpfs_pkg::ADDR_OT_RESP:
                begin
                    if (st.wstrb[0] && (wbyte == dpfs_pkg::OT_LATCH
                                        || wbyte == dpfs_pkg::OT_RESTART))
                        next_st.ot_resp = wbyte;
                    else if (st.wstrb[0])
                        next_st.bresp = dpfs_pkg::RESP_SLVERR;
                end
                dpfs_pkg::ADDR_BUS_STATUS, dpfs_pkg::ADDR_FAULT, dpfs_pkg::ADDR_CML,
                dpfs_pkg::ADDR_READBACK, dpfs_pkg::ADDR_LIVE:
                begin
                    // read-only status, write ignored
                    next_st.bresp = dpfs_pkg::RESP_OKAY;
                end
                default:
                begin
                    next_st.bresp = dpfs_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end

        // read channel: one outstanding read
        if (s_axi_arvalid && st.arready)
        begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = dpfs_pkg::RESP_OKAY;
            next_st.rdata = '0;
            unique case (ra)
                dpfs_pkg::ADDR_BUS_STATUS:
                    next_st.rdata[7:0] = {nib1.nib, nib0.nib};
                dpfs_pkg::ADDR_FAULT:
                    next_st.rdata[FAULT_W-1:0] = st.faults;
                dpfs_pkg::ADDR_CML:
                    next_st.rdata[7:0] = st.cml;
                dpfs_pkg::ADDR_READBACK:
                    next_st.rdata[15:0] = st.readback;
                dpfs_pkg::ADDR_OC_RESP:
                    next_st.rdata[7:0] = st.oc_resp;
                dpfs_pkg::ADDR_OT_RESP:
                    next_st.rdata[7:0] = st.ot_resp;
                dpfs_pkg::ADDR_LIVE:
                    next_st.rdata[4:0] = {st.good, st.live, st.owner};
                default:
                    next_st.rresp = dpfs_pkg::RESP_SLVERR;
            endcase
        end
        if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.owner <= dpfs_pkg::OWNER_RST;
            st.cml <= dpfs_pkg::CML_NONE;
            st.readback <= dpfs_pkg::RB_NONE;
            st.oc_resp <= dpfs_pkg::OC_RESP_RST;
            st.ot_resp <= dpfs_pkg::OT_RESP_RST;
            st.alert_n <= 2'b11;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign alert_n = st.alert_n;
    assign output_good_flag = st.good;
    assign owner_port = st.owner;

endmodule
`default_nettype wire

/* File: dpfs_pkg.sv */
// package: constants and types for the dual-port fault status block
package dpfs_pkg;

    // register byte offsets on the AXI4-Lite slave
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_BUS_STATUS = 8'h00;
    localparam logic [7:0] ADDR_FAULT = 8'h04;
    localparam logic [7:0] ADDR_CML = 8'h08;
    localparam logic [7:0] ADDR_READBACK = 8'h0c;
    localparam logic [7:0] ADDR_OC_RESP = 8'h10;
    localparam logic [7:0] ADDR_OT_RESP = 8'h14;
    localparam logic [7:0] ADDR_LIVE = 8'h18;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // sticky fault vector layout
    localparam int FAULT_W = 14;
    localparam int F_OV_FAULT = 0;
    localparam int F_OV_WARN = 1;
    localparam int F_UV_FAULT = 2;
    localparam int F_UV_WARN = 3;
    localparam int F_OC_FAULT = 4;
    localparam int F_OC_WARN = 5;
    localparam int F_IN_FAULT = 6;
    localparam int F_IN_WARN = 7;
    localparam int F_UNKNOWN = 8;
    localparam int F_INTERNAL = 9;
    localparam int F_EXTERNAL = 10;
    localparam int F_SHUTDOWN = 11;
    localparam int F_ORING_PASS = 12;
    localparam int F_ORING_FAIL = 13;
    // a passed isolation test is latched but is no reason to alert
    localparam logic [FAULT_W-1:0] FAULT_ALERT_MASK = 14'h2fff;

    // communication error status and read-back word
    localparam logic [7:0] CML_INVALID_CMD = 8'h80;
    localparam logic [15:0] RB_INVALID_CMD = 16'h0002;
    localparam logic [7:0] CML_NONE = 8'h00;
    localparam logic [15:0] RB_NONE = 16'h0000;

    // fault-response codes
    localparam logic [7:0] OC_LATCH = 8'hc0;
    localparam logic [7:0] OC_HICCUP = 8'hf8;
    localparam logic [7:0] OT_LATCH = 8'h80;
    localparam logic [7:0] OT_RESTART = 8'hc0;
    localparam logic [7:0] OC_RESP_RST = OC_LATCH;
    localparam logic [7:0] OT_RESP_RST = OT_LATCH;

    // per-port bus status nibble, pending bits [3:1], bit 0 is control
    localparam logic [2:0] NIB_TAKE = 3'h3;
    localparam logic [2:0] NIB_LOSE = 3'h2;
    localparam logic [2:0] NIB_REJECT = 3'h6;
    localparam logic [2:0] NIB_NONE = 3'h0;

    localparam logic OWNER_RST = 1'b0;

    typedef enum logic [1:0] {
        DPFS_CMD_NORMAL = 2'b00,
        DPFS_CMD_CLEAR = 2'b01,
        DPFS_CMD_TAKEOVER = 2'b10,
        DPFS_CMD_INVALID = 2'b11
    } dpfs_cmd_e;

endpackage

/* File: dpfs_nib_if.sv */
// interface: events into one port's bus status tracker and its nibble out
`timescale 1ns/100ps
`default_nettype none
interface dpfs_nib_if;
    logic clr;
    logic take;
    logic lose;
    logic reject;
    logic owner;
    logic [3:0] nib;
    modport tracker (input clr, input take, input lose, input reject, input owner, output nib);
    modport ctrl (output clr, output take, output lose, output reject, output owner, input nib);
endinterface
`default_nettype wire

/* File: dpfs_nibble.sv */
// module: bus status nibble tracker of one management port
`timescale 1ns/100ps
`default_nettype none
module dpfs_nibble
(
    input wire logic aclk,
    input wire logic aresetn,
    dpfs_nib_if.tracker nif
);

    typedef struct packed {
        logic [2:0] pend;
    } dpfs_nib_s;

    dpfs_nib_s st;
    dpfs_nib_s next_st;

    always_comb
    begin
        logic [2:0] set_bits;
        set_bits = dpfs_pkg::NIB_NONE;
        if (nif.take)
            set_bits = set_bits | dpfs_pkg::NIB_TAKE;
        if (nif.lose)
            set_bits = set_bits | dpfs_pkg::NIB_LOSE;
        if (nif.reject)
            set_bits = set_bits | dpfs_pkg::NIB_REJECT;
        next_st = st;
        // a new event in the clearing cycle survives the clear
        next_st.pend = (nif.clr ? dpfs_pkg::NIB_NONE : st.pend) | set_bits;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '{pend: dpfs_pkg::NIB_NONE};
        else
            st <= next_st;
    end

    assign nif.nib = {st.pend, nif.owner};

endmodule
`default_nettype wire

/* File: dpfs_host_model.sv */
// partner: behavioural management host that turns a request into a command pulse
`timescale 1ns/100ps
`default_nettype none
module dpfs_host_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req,
    input wire dpfs_pkg::dpfs_cmd_e req_code,
    output var logic cmd_valid,
    output var dpfs_pkg::dpfs_cmd_e cmd_code
);
    // between commands the code lines toggle, so a stale code never looks live
    always_ff @(posedge aclk)
    begin
        cmd_valid <= aresetn && req;
        if (!aresetn)
            cmd_code <= dpfs_pkg::DPFS_CMD_NORMAL;
        else
            cmd_code <= req ? req_code : dpfs_pkg::dpfs_cmd_e'(~cmd_code);
    end
endmodule
`default_nettype wire

/* File: dpfs_top_asserts.sv */
// checker: port-level properties of the dual-port fault status block
`timescale 1ns/100ps
`default_nettype none
module dpfs_top_asserts
#(
    parameter int FAULT_W = 14
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic port0_cmd_valid,
    input wire dpfs_pkg::dpfs_cmd_e port0_cmd_code,
    input wire logic port1_cmd_valid,
    input wire dpfs_pkg::dpfs_cmd_e port1_cmd_code,
    input wire logic [FAULT_W-1:0] fault_cond,
    input wire logic output_in_regulation,
    input wire logic shutdown_imminent,
    input wire logic [1:0] alert_n,
    input wire logic output_good_flag,
    input wire logic owner_port
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic p0_tk = port0_cmd_valid && port0_cmd_code == dpfs_pkg::DPFS_CMD_TAKEOVER;
    wire logic p1_tk = port1_cmd_valid && port1_cmd_code == dpfs_pkg::DPFS_CMD_TAKEOVER;
    wire logic p0_bad = port0_cmd_valid && port0_cmd_code[0] == port0_cmd_code[1];
    wire logic p1_bad = port1_cmd_valid && port1_cmd_code[0] == port1_cmd_code[1];
    ////////////////////////////////////////////////////////////////////////////////
    take_p1_a: assert property (p1_tk && !p0_tk && !owner_port |=> owner_port && alert_n == 2'h0)
        else $error("port 1 takeover not seen");
    take_p0_a: assert property (p0_tk && owner_port |=> !owner_port && alert_n == 2'h0)
        else $error("port 0 takeover not seen");
    owner_hold_a: assert property (!p0_tk && !p1_tk |=> $stable(owner_port))
        else $error("owner changed without takeover");
    reject_p1_a: assert property (p1_bad && !owner_port |=> !alert_n[1] && !owner_port)
        else $error("port 1 command not rejected");
    reject_p0_a: assert property (p0_bad && owner_port && !p1_tk |=> !alert_n[0] && owner_port)
        else $error("port 0 command not rejected");
    invalid_p0_a: assert property (p0_bad && port0_cmd_code[0] && !owner_port |=> !alert_n[0])
        else $error("invalid command gave no alert");
    fault_alert_a: assert property ((fault_cond & dpfs_pkg::FAULT_ALERT_MASK) != 0 |=> alert_n == 2'h0)
        else $error("fault gave no alerts");
    keep_other_a: assert property (port1_cmd_valid && port1_cmd_code == dpfs_pkg::DPFS_CMD_CLEAR
        && owner_port && !alert_n[0] && !port0_cmd_valid |=> !alert_n[0])
        else $error("owner clear dropped other alert");
    good_flag_a: assert property (1'b1 |=> output_good_flag == $past(output_in_regulation && !shutdown_imminent))
        else $error("output good flag wrong");
    write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:4] s_axi_bvalid)
        else $error("write response missing");
endmodule
bind dpfs_top dpfs_top_asserts #(.FAULT_W(FAULT_W)) u_asserts (.*);
`default_nettype wire

/* File: tb.sv */
// testbench: command table walk, register access and sticky status checks
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct {logic f; logic p; logic [1:0] c; logic [1:0] al; logic ow;
        logic [7:0] bus; logic [7:0] cml;} dpfs_row_s;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, alert_n;
    logic port0_cmd_valid, port1_cmd_valid, output_good_flag, owner_port;
    dpfs_pkg::dpfs_cmd_e port0_cmd_code, port1_cmd_code, rc0, rc1;
    logic req0 = 1'b0, req1 = 1'b0;
    logic [13:0] fault_cond = 14'h0;
    logic main_output_on = 1'b0, output_in_regulation = 1'b0, shutdown_imminent = 1'b0;
    int num_errors = 0, checks = 0;
    dpfs_row_s rows [14];
    dpfs_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .port0_cmd_valid, .port0_cmd_code, .port1_cmd_valid, .port1_cmd_code, .fault_cond,
        .main_output_on, .output_in_regulation, .shutdown_imminent, .alert_n,
        .output_good_flag, .owner_port);
    dpfs_host_model u_h0 (.aclk, .aresetn, .req(req0), .req_code(rc0),
        .cmd_valid(port0_cmd_valid), .cmd_code(port0_cmd_code));
    dpfs_host_model u_h1 (.aclk, .aresetn, .req(req1), .req_code(rc1),
        .cmd_valid(port1_cmd_valid), .cmd_code(port1_cmd_code));
    ////////////////////////////////////////////////////////////////////////////////
    task end_sim();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wrchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (!s_axi_arready) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask
    task cmd(input logic p, input logic [1:0] c);
        @(posedge aclk);
        if (p)
        begin
            req1 <= 1'b1;
            rc1 <= dpfs_pkg::dpfs_cmd_e'(c);
        end
        else
        begin
            req0 <= 1'b1;
            rc0 <= dpfs_pkg::dpfs_cmd_e'(c);
        end
        @(posedge aclk);
        req0 <= 1'b0;
        req1 <= 1'b0;
        settle();
    endtask
    task settle();
        repeat (3) @(posedge aclk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #4 aclk = ~aclk;
    end
    initial
    begin
        #50us;
        num_errors++;
        end_sim();
    end
    initial
    begin
        rows = '{'{0, 1, 2'h0, 2'h1, 0, 8'hc1, 8'h00},
            '{0, 1, 2'h1, 2'h3, 0, 8'h01, 8'h00},
            '{0, 0, 2'h0, 2'h3, 0, 8'h01, 8'h00},
            '{1, 0, 2'h0, 2'h0, 0, 8'h01, 8'h00},
            '{0, 1, 2'h2, 2'h0, 1, 8'h74, 8'h00},
            '{0, 1, 2'h1, 2'h2, 1, 8'h14, 8'h00},
            '{0, 0, 2'h1, 2'h3, 1, 8'h10, 8'h00},
            '{0, 0, 2'h0, 2'h2, 1, 8'h1c, 8'h00},
            '{0, 0, 2'h1, 2'h3, 1, 8'h10, 8'h00},
            '{0, 1, 2'h3, 2'h1, 1, 8'h10, 8'h80},
            '{0, 1, 2'h1, 2'h3, 1, 8'h10, 8'h00},
            '{0, 0, 2'h2, 2'h0, 0, 8'h47, 8'h00},
            '{0, 0, 2'h1, 2'h1, 0, 8'h41, 8'h00},
            '{0, 1, 2'h1, 2'h3, 0, 8'h01, 8'h00}};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        chk(alert_n, 32'h3);
        chk(owner_port, 32'h0);
        rdchk(dpfs_pkg::ADDR_OC_RESP, 32'hc0, 2'h0);
        rdchk(dpfs_pkg::ADDR_OT_RESP, 32'h80, 2'h0);
        rdchk(dpfs_pkg::ADDR_BUS_STATUS, 32'h01, 2'h0);
        foreach (rows[i])
        begin
            if (rows[i].f)
            begin
                @(posedge aclk);
                fault_cond <= 14'h0001;
                @(posedge aclk);
                fault_cond <= 14'h0000;
                settle();
            end
            else
                cmd(rows[i].p, rows[i].c);
            chk(alert_n, rows[i].al);
            chk(owner_port, rows[i].ow);
            rdchk(dpfs_pkg::ADDR_BUS_STATUS, rows[i].bus, 2'h0);
            rdchk(dpfs_pkg::ADDR_CML, rows[i].cml, 2'h0);
            rdchk(dpfs_pkg::ADDR_READBACK, rows[i].cml[7] ? 32'h2 : 32'h0, 2'h0);
        end
        wrchk(dpfs_pkg::ADDR_OC_RESP, 32'hf8, 2'h0);
        wrchk(dpfs_pkg::ADDR_OC_RESP, 32'h12, 2'h2);
        wrchk(dpfs_pkg::ADDR_OT_RESP, 32'hc0, 2'h0);
        wrchk(dpfs_pkg::ADDR_OT_RESP, 32'hf8, 2'h2);
        @(posedge aclk);
        fault_cond <= 14'h3fff;
        @(posedge aclk);
        fault_cond <= 14'h0000;
        settle();
        rdchk(dpfs_pkg::ADDR_FAULT, 32'h3fff, 2'h0);
        cmd(1'b1, 2'h1);
        rdchk(dpfs_pkg::ADDR_FAULT, 32'h3fff, 2'h0);
        @(posedge aclk);
        fault_cond <= 14'h0004;
        cmd(1'b0, 2'h1);
        rdchk(dpfs_pkg::ADDR_FAULT, 32'h0004, 2'h0);
        rdchk(dpfs_pkg::ADDR_OC_RESP, 32'hf8, 2'h0);
        rdchk(dpfs_pkg::ADDR_OT_RESP, 32'hc0, 2'h0);
        @(posedge aclk);
        fault_cond <= 14'h0000;
        cmd(1'b0, 2'h1);
        rdchk(dpfs_pkg::ADDR_FAULT, 32'h0, 2'h0);
        chk(alert_n, 32'h3);
        @(posedge aclk);
        main_output_on <= 1'b1;
        output_in_regulation <= 1'b1;
        settle();
        chk(output_good_flag, 32'h1);
        rdchk(dpfs_pkg::ADDR_LIVE, 32'h16, 2'h0);
        @(posedge aclk);
        shutdown_imminent <= 1'b1;
        settle();
        chk(output_good_flag, 32'h0);
        rdchk(dpfs_pkg::ADDR_LIVE, 32'h0e, 2'h0);
        wrchk(dpfs_pkg::ADDR_BUS_STATUS, 32'hff, 2'h0);
        rdchk(dpfs_pkg::ADDR_BUS_STATUS, 32'h01, 2'h0);
        rdchk(8'h1c, 32'h0, 2'h2);
        cmd(1'b1, 2'h2);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        chk(owner_port, 32'h0);
        chk(alert_n, 32'h3);
        rdchk(dpfs_pkg::ADDR_OC_RESP, 32'hc0, 2'h0);
        end_sim();
    end
endmodule
`default_nettype wire
